// ### rtl/ers_pkg.sv
package ers_pkg;
  // clock and interval timing
  localparam int CLK_MHZ = 200;
  localparam int BATT_TEST_MS = 12;
  localparam int FIRST_CATCH_MS = 5;
  localparam int BATT_TEST_CYC = BATT_TEST_MS * CLK_MHZ * 1000;
  localparam int FIRST_CATCH_CYC = FIRST_CATCH_MS * CLK_MHZ * 1000;
  // shutter time is counted in ticks of this length
  localparam int SHUT_TICK_NS = 1000;
  localparam int SHUT_TICK_CYC = (SHUT_TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 22;
  localparam int TICK_W = 8;
  // timing capacitor threshold: 5/8 of supply
  localparam int CAP_FRAC_NUM = 5;
  localparam int CAP_FRAC_SHIFT = 3;

  // register byte offsets (low address bits only)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_APERTURE = 8'h04;
  localparam logic [7:0] ADDR_SHUTTER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int EV_LOW_VOLT = 0;
  localparam int EV_FIRST_CATCH = 1;
  localparam int EV_DIAPH_STOP = 2;
  localparam int EV_EXPO_END = 3;
  localparam int EV_CYCLE_DONE = 4;
  localparam int EV_W = 5;
  localparam int STATE_AP_LSB = 16;

  // reset values
  localparam logic CTRL_ENABLE_RST = 1'b0;
  localparam logic [7:0] APERTURE_RST = 8'h00;
  localparam logic [15:0] SHUTTER_RST = 16'h0001;
  localparam logic [4:0] MASK_RST = 5'h00;
  // pins: release_n, end_of_cycle_n, curtain_n, aperture pulse, battery low
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_RST = 5'h18;
  localparam int PIN_REL = 4;
  localparam int PIN_EOC = 3;
  localparam int PIN_CURT = 2;
  localparam int PIN_APUL = 1;
  localparam int PIN_BATT = 0;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_BATT = 9'h002,
    S_FIRST = 9'h004,
    S_DIAPH = 9'h008,
    S_CURTAIN = 9'h010,
    S_SHUTTER = 9'h020,
    S_CLOSE = 9'h040,
    S_LOCKOUT = 9'h080,
    S_SPARE = 9'h100
  } ers_state_t;
endpackage : ers_pkg

// ### rtl/ers_top.sv
// How it works
// R1: release restarts flow, begins exposure calculation
// R2: latch low keeps supply transistor on
// R3: display stays dark while blanking high
// R4: start: both magnet controls low, battery test
// R5: weak battery raises low voltage flag
// R6: low voltage cancels cycle, blocks release
// R7: after test, second curtain high, diaphragm low
// R8: hold that five ms, then curtain low
// R9: that combination drives release magnet coil
// R10: count aperture pulses against stored value
// R11: count equal: diaphragm control goes high
// R12: diaphragm control high switches magnet off
// R13: curtain open, capacitor at 5/8: start low
// R14: shutter count starts on start falling edge
// R15: count done: second curtain control high
// R16: curtain control high releases second curtain
// R17: end switch low: clear, latch high
// R18: latch high turns supply transistor off
// R19: intervals counted in system clock cycles
//
// The implementer's own choices: the AHB-Lite register port and the address map.
module ers_top #(
  parameter int unsigned BATT_TEST_CYCLES = ers_pkg::BATT_TEST_CYC,
  parameter int unsigned FIRST_CATCH_CYCLES = ers_pkg::FIRST_CATCH_CYC,
  parameter int APERTURE_W = 8,
  parameter int SHUTTER_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic release_switch_n,
  input wire logic end_of_cycle_switch_n,
  input wire logic curtain_switch_n,
  input wire logic aperture_pulse,
  input wire logic battery_low,
  input wire logic [7:0] timing_capacitor,
  input wire logic [7:0] supply_level,
  output logic power_latch,
  output logic supply_transistor_on,
  output logic display_blank,
  output logic low_voltage_flag,
  output logic diaphragm_magnet_ctrl,
  output logic second_curtain_magnet_ctrl,
  output logic release_magnet_drive,
  output logic diaphragm_magnet_on,
  output logic second_curtain_magnet_on,
  output logic count_start,
  output logic power_up_clear,
  output logic [ers_pkg::EV_W-1:0] status_view
);
  import ers_pkg::*;

  ers_state_t state_reg;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] sync3_reg;
  logic [PIN_W-1:0] pin_reg;
  logic [PIN_W-1:0] pin_prev_reg;
  logic [PIN_W-1:0] pin_raw;
  logic release_fall;
  logic eoc_closed;
  logic curtain_open;
  logic apul_rise;
  logic batt_low_s;
  logic [TIMER_W-1:0] timer_reg;
  logic [TICK_W-1:0] tick_reg;
  logic [SHUTTER_W-1:0] shut_cnt_reg;
  logic [APERTURE_W-1:0] ap_cnt_reg;
  logic count_start_prev_reg;
  logic cap_charged;
  logic [10:0] cap_scaled;
  logic [10:0] supply_scaled;
  logic ctrl_enable_reg;
  logic [APERTURE_W-1:0] aperture_reg;
  logic [SHUTTER_W-1:0] shutter_reg;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] ev_reg;
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_status_clr;
  logic [31:0] rd_mux;
  logic shutter_done;

  // pin order must match the PIN_* bit positions of the package
  assign pin_raw = {release_switch_n, end_of_cycle_switch_n, curtain_switch_n, aperture_pulse, battery_low};

  // three-stage synchroniser per pin; a level counts once stages two and three agree
  // a pin change reaches pin_reg four edges later; the edge detectors pulse in that same cycle and are acted on one edge after that
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync1_reg[i] <= PIN_RST[i];
        sync2_reg[i] <= PIN_RST[i];
        sync3_reg[i] <= PIN_RST[i];
        pin_reg[i] <= PIN_RST[i];
        pin_prev_reg[i] <= PIN_RST[i];
      end else if (ce) begin
        sync1_reg[i] <= pin_raw[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
        pin_prev_reg[i] <= pin_reg[i];
      end
    end
  end

  // filtered levels; release and aperture act on edges, the switches on levels
  assign release_fall = pin_prev_reg[PIN_REL] & ~pin_reg[PIN_REL];
  assign eoc_closed = ~pin_reg[PIN_EOC];
  assign curtain_open = pin_reg[PIN_CURT];
  assign apul_rise = pin_reg[PIN_APUL] & ~pin_prev_reg[PIN_APUL];
  assign batt_low_s = pin_reg[PIN_BATT];

  // capacitor comparison without a divider: cap * 8 >= supply * 5
  assign cap_scaled = {timing_capacitor, 3'h0};
  assign supply_scaled = 11'(supply_level * CAP_FRAC_NUM);
  assign cap_charged = cap_scaled >= supply_scaled; // R13
  assign shutter_done = (shut_cnt_reg >= shutter_reg); // R15

  // sequencer: one state per phase of the exposure cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      power_latch <= 1'b1;
      display_blank <= 1'b0;
      low_voltage_flag <= 1'b0;
      diaphragm_magnet_ctrl <= 1'b1;
      second_curtain_magnet_ctrl <= 1'b1;
      power_up_clear <= 1'b0;
      ev_reg <= '0;
    end else if (ce) begin
      power_up_clear <= 1'b0;
      ev_reg <= '0;
      case (state_reg)
        // a release while the enable bit is clear is ignored
        S_IDLE: begin
          if (release_fall && ctrl_enable_reg) begin
            state_reg <= S_BATT; // R1
            power_latch <= 1'b0;
            display_blank <= 1'b1; // R3
            low_voltage_flag <= 1'b0;
            diaphragm_magnet_ctrl <= 1'b0; // R4
            second_curtain_magnet_ctrl <= 1'b0; // R4
          end
        end
        // battery under load; a weak cell wins over the end of the interval
        S_BATT: begin
          if (batt_low_s) begin
            // weak cell: drop everything and refuse the release
            state_reg <= S_LOCKOUT; // R6
            low_voltage_flag <= 1'b1; // R5
            power_latch <= 1'b1; // R6
            display_blank <= 1'b0;
            diaphragm_magnet_ctrl <= 1'b1;
            second_curtain_magnet_ctrl <= 1'b1;
            ev_reg[EV_LOW_VOLT] <= 1'b1;
          end else if (timer_reg == TIMER_W'(BATT_TEST_CYCLES - 1)) begin // R19
            state_reg <= S_FIRST;
            second_curtain_magnet_ctrl <= 1'b1; // R7
          end
        end
        // release magnet pulse frees the first catch
        S_FIRST: begin
          if (timer_reg == TIMER_W'(FIRST_CATCH_CYCLES - 1)) begin // R19
            state_reg <= S_DIAPH;
            second_curtain_magnet_ctrl <= 1'b0; // R8
            ev_reg[EV_FIRST_CATCH] <= 1'b1;
          end
        end
        // diaphragm runs until the pulse count reaches the stored value
        S_DIAPH: begin
          if (ap_cnt_reg == aperture_reg) begin
            state_reg <= S_CURTAIN;
            diaphragm_magnet_ctrl <= 1'b1; // R11
            ev_reg[EV_DIAPH_STOP] <= 1'b1;
          end
        end
        // wait for the own count start edge so the shutter count starts on a clean cycle
        S_CURTAIN: begin
          if (count_start_prev_reg && !count_start) begin
            state_reg <= S_SHUTTER; // R14
          end
        end
        // exposure runs until the programmed time is used up
        S_SHUTTER: begin
          if (shutter_done) begin
            state_reg <= S_CLOSE;
            second_curtain_magnet_ctrl <= 1'b1; // R15
            ev_reg[EV_EXPO_END] <= 1'b1;
          end
        end
        // cycle ends on the end switch; the clear pulse lasts one cycle
        S_CLOSE: begin
          if (eoc_closed) begin
            state_reg <= S_IDLE;
            power_up_clear <= 1'b1; // R17
            power_latch <= 1'b1; // R17
            display_blank <= 1'b0;
            ev_reg[EV_CYCLE_DONE] <= 1'b1;
          end
        end
        S_LOCKOUT: begin
          // stays refused until the release button is let go
          if (pin_reg[PIN_REL]) begin
            state_reg <= S_IDLE;
          end
        end
        // unreachable codes fall back to idle with supply dropped and magnets off
        default: begin
          state_reg <= S_IDLE;
          power_latch <= 1'b1;
          diaphragm_magnet_ctrl <= 1'b1;
          second_curtain_magnet_ctrl <= 1'b1;
        end
      endcase
    end
  end

  // interval timer, restarted on every phase change
  // it clears to zero at its end value, on the same edge on which the sequencer leaves the phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_reg <= '0;
    end else if (ce) begin
      if (state_reg == S_BATT && timer_reg != TIMER_W'(BATT_TEST_CYCLES - 1)) begin
        timer_reg <= timer_reg + 1'b1; // R19
      end else if (state_reg == S_FIRST && timer_reg != TIMER_W'(FIRST_CATCH_CYCLES - 1)) begin
        timer_reg <= timer_reg + 1'b1; // R19
      end else begin
        timer_reg <= '0;
      end
    end
  end

  // aperture pulse counter, cleared at the release
  // counting stops at the target, so a late pulse cannot overshoot it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_cnt_reg <= '0;
    end else if (ce) begin
      if (state_reg == S_IDLE) begin
        ap_cnt_reg <= '0; // R1
      end else if (state_reg == S_DIAPH && apul_rise && ap_cnt_reg != aperture_reg) begin
        ap_cnt_reg <= ap_cnt_reg + 1'b1; // R10
      end
    end
  end

  // count start comparator output and its edge history
  // it falls once per cycle and is only re-armed in idle, so one cycle gives one shutter count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_start <= 1'b1;
      count_start_prev_reg <= 1'b1;
    end else if (ce) begin
      count_start_prev_reg <= count_start;
      if (state_reg == S_IDLE) begin
        count_start <= 1'b1;
      end else if (state_reg == S_CURTAIN && curtain_open && cap_charged) begin
        count_start <= 1'b0; // R13
      end
    end
  end

  // shutter time in ticks; a programmed value of zero closes at once
  // the tick divider keeps the counter narrow at the cost of one tick of resolution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= '0;
      shut_cnt_reg <= '0;
    end else if (ce) begin
      if (state_reg != S_SHUTTER) begin
        tick_reg <= '0;
        shut_cnt_reg <= '0;
      end else if (tick_reg == TICK_W'(SHUT_TICK_CYC - 1)) begin
        tick_reg <= '0;
        shut_cnt_reg <= shut_cnt_reg + 1'b1; // R14
      end else begin
        tick_reg <= tick_reg + 1'b1;
      end
    end
  end

  // interface drives: low control means magnet energised
  assign supply_transistor_on = ~power_latch; // R2 R18
  assign release_magnet_drive = second_curtain_magnet_ctrl & ~diaphragm_magnet_ctrl; // R9
  assign diaphragm_magnet_on = ~diaphragm_magnet_ctrl; // R12
  assign second_curtain_magnet_on = ~second_curtain_magnet_ctrl; // R16

  // ahb-lite slave: zero wait states, stalls only while the clock enable is low
  // a write lands one edge after its address phase, so a pipelined read of that word sees the old value
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready && ce;
  assign rd_status_clr = addr_ok && !hwrite && haddr[7:0] == ADDR_STATUS;

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_CTRL: rd_mux[CTRL_ENABLE_BIT] = ctrl_enable_reg;
      ADDR_APERTURE: rd_mux[APERTURE_W-1:0] = aperture_reg;
      ADDR_SHUTTER: rd_mux[SHUTTER_W-1:0] = shutter_reg;
      ADDR_STATUS: rd_mux[EV_W-1:0] = status_reg;
      ADDR_MASK: rd_mux[EV_W-1:0] = mask_reg;
      ADDR_STATE: begin
        rd_mux[8:0] = state_reg;
        rd_mux[STATE_AP_LSB +: APERTURE_W] = ap_cnt_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase: latch write target, capture read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  // data phase writes; they take effect at once, so software should reprogram only while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_enable_reg <= CTRL_ENABLE_RST;
      aperture_reg <= APERTURE_RST[APERTURE_W-1:0];
      shutter_reg <= SHUTTER_RST[SHUTTER_W-1:0];
      mask_reg <= MASK_RST;
    end else if (ce && wr_pend_reg) begin
      case (wr_addr_reg)
        ADDR_CTRL: ctrl_enable_reg <= hwdata[CTRL_ENABLE_BIT];
        ADDR_APERTURE: aperture_reg <= hwdata[APERTURE_W-1:0];
        ADDR_SHUTTER: shutter_reg <= hwdata[SHUTTER_W-1:0];
        ADDR_MASK: mask_reg <= hwdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status, cleared by a read; an event in the clearing cycle survives
  // the mask only gates the interrupt, status bits set regardless
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else if (ce) begin
      status_reg <= (rd_status_clr ? '0 : status_reg) | ev_reg;
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(status_reg & mask_reg);
  assign status_view = status_reg;
endmodule : ers_top

// ### verification/ers_sva.sv
module ers_sva #(
  parameter int unsigned BATT_TEST_CYCLES = 40,
  parameter int unsigned FIRST_CATCH_CYCLES = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_latch,
  input wire logic supply_transistor_on,
  input wire logic display_blank,
  input wire logic low_voltage_flag,
  input wire logic diaphragm_magnet_ctrl,
  input wire logic second_curtain_magnet_ctrl,
  input wire logic release_magnet_drive,
  input wire logic diaphragm_magnet_on,
  input wire logic second_curtain_magnet_on,
  input wire logic count_start,
  input wire logic power_up_clear,
  input wire logic [7:0] timing_capacitor,
  input wire logic [7:0] supply_level
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic pl = power_latch;
  wire logic dia = diaphragm_magnet_ctrl;
  wire logic sc = second_curtain_magnet_ctrl;
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since power was latched on, and length of the current curtain-control high spell
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_cnt <= 32'h0;
      hi_cnt <= 32'h0;
    end else begin
      lo_cnt <= pl ? 32'h0 : lo_cnt + 32'h1;
      hi_cnt <= sc ? hi_cnt + 32'h1 : 32'h0;
    end
  end
  // count_start still high tells the catch pulse apart from the closing curtain edge
  sequence s_catch_up; $rose(sc) && count_start && !pl; endsequence
  sequence s_catch_down; $fell(sc) && count_start && !$fell(pl); endsequence
  sequence s_clear_end; !power_up_clear && pl; endsequence
  property p_supply; supply_transistor_on == !pl; endproperty
  a_supply: assert property (p_supply)
    else $error("supply switch wrong");
  property p_release; release_magnet_drive == (sc && !dia); endproperty
  a_release: assert property (p_release)
    else $error("release coil wrong");
  property p_coils; diaphragm_magnet_on == !dia && second_curtain_magnet_on == !sc; endproperty
  a_coils: assert property (p_coils)
    else $error("magnet drive wrong");
  property p_start; $fell(pl) |-> !dia && !sc && display_blank; endproperty
  a_start: assert property (p_start)
    else $error("bad frame start");
  property p_first; s_catch_up |-> lo_cnt == BATT_TEST_CYCLES && !dia; endproperty
  a_first: assert property (p_first)
    else $error("battery test length wrong");
  property p_catch; s_catch_down |-> hi_cnt == FIRST_CATCH_CYCLES && !dia; endproperty
  a_catch: assert property (p_catch)
    else $error("catch pulse length wrong");
  property p_lock; $rose(low_voltage_flag) |-> pl && dia && sc && !display_blank; endproperty
  a_lock: assert property (p_lock)
    else $error("lockout incomplete");
  property p_thresh;
    $fell(count_start) |-> {$past(timing_capacitor), 3'h0} >= 11'($past(supply_level)) * 11'h5;
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("count start before threshold");
  property p_clear; $rose(power_up_clear) |-> pl && !display_blank ##1 s_clear_end; endproperty
  a_clear: assert property (p_clear)
    else $error("cycle end wrong");
endmodule : ers_sva

bind ers_top ers_sva #(.BATT_TEST_CYCLES(BATT_TEST_CYCLES), .FIRST_CATCH_CYCLES(FIRST_CATCH_CYCLES)) i_sva (
  .hclk, .hresetn, .power_latch, .supply_transistor_on, .display_blank, .low_voltage_flag,
  .diaphragm_magnet_ctrl, .second_curtain_magnet_ctrl, .release_magnet_drive, .diaphragm_magnet_on,
  .second_curtain_magnet_on, .count_start, .power_up_clear, .timing_capacitor, .supply_level
);

// ### verification/ers_partner.sv
module ers_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] gap,
  input wire logic power_latch,
  input wire logic release_magnet_drive,
  input wire logic diaphragm_magnet_on,
  input wire logic second_curtain_magnet_on,
  output logic curtain_switch_n,
  output logic end_of_cycle_switch_n,
  output logic aperture_pulse,
  output logic [7:0] timing_capacitor,
  output logic [7:0] supply_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic freed;
  logic [4:0] tick;
  // supply moves a little with each frame, so the threshold meets more than one level
  assign supply_level = 8'hb8 + {4'h0, gap};
  // mechanism rests while supply is off, so every frame starts from a cocked shutter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn || power_latch) begin
      freed <= 1'b0;
      tick <= 5'h0;
      aperture_pulse <= 1'b0;
      curtain_switch_n <= 1'b0;
      end_of_cycle_switch_n <= 1'b1;
      timing_capacitor <= 8'h0;
    end else begin
      tick <= tick + 5'h1;
      if (release_magnet_drive) freed <= 1'b1;
      if (freed && !release_magnet_drive && diaphragm_magnet_on && tick > {1'b0, gap} + 5'h8) begin
        aperture_pulse <= !aperture_pulse;
        tick <= 5'h0;
      end
      if (freed && !diaphragm_magnet_on) curtain_switch_n <= 1'b1;
      if (curtain_switch_n && timing_capacitor != 8'hff) timing_capacitor <= timing_capacitor + 8'h1;
      if (curtain_switch_n && !second_curtain_magnet_on) end_of_cycle_switch_n <= 1'b0;
    end
  end
endmodule : ers_partner

// ### verification/tb_exposure_release_sequencer.sv
module tb_exposure_release_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import ers_pkg::*;
  localparam int BT = 40;
  localparam int FC = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic rel_n = 1'b1;
  logic battery_low = 1'b0;
  logic [3:0] gap = 4'h0;
  logic rd = 1'b0;
  logic sc_q = 1'b1;
  logic hreadyout, irq, power_latch, supply_transistor_on, display_blank, low_voltage_flag, power_up_clear;
  logic diaphragm_magnet_ctrl, second_curtain_magnet_ctrl, release_magnet_drive, count_start;
  logic diaphragm_magnet_on, second_curtain_magnet_on, curtain_switch_n, end_of_cycle_switch_n, aperture_pulse;
  logic [7:0] timing_capacitor, supply_level;
  logic [31:0] hrdata;
  logic hresp;
  logic [EV_W-1:0] status_view;
  logic [63:0] rq[$];
  int tq[$];
  int sh = 0;
  int cyc = 0;
  int err_total = 0;
  int compares = 0;
  ers_top #(.BATT_TEST_CYCLES(BT), .FIRST_CATCH_CYCLES(FC)) i_dut (
    .hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .release_switch_n(rel_n), .end_of_cycle_switch_n,
    .curtain_switch_n, .aperture_pulse, .battery_low, .timing_capacitor, .supply_level, .power_latch,
    .supply_transistor_on, .display_blank, .low_voltage_flag, .diaphragm_magnet_ctrl, .second_curtain_magnet_ctrl,
    .release_magnet_drive, .diaphragm_magnet_on, .second_curtain_magnet_on, .count_start, .power_up_clear,
    .status_view
  );
  ers_partner i_far (
    .hclk, .hresetn, .gap, .power_latch, .release_magnet_drive, .diaphragm_magnet_on, .second_curtain_magnet_on,
    .curtain_switch_n, .end_of_cycle_switch_n, .aperture_pulse, .timing_capacitor, .supply_level
  );
  // free-running bus clock
  initial forever #2.5 hclk = ~hclk;
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // s widens the match to a small window, for counts whose last edge may land up to two cycles late
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input int s);
    compares++;
    if ((g >= e && g <= e + 32'(s)) !== 1'b1) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // one single word transfer; a read leaves its mask and expected value for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic [31:0] e);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd <= !w;
    if (!w) rq.push_back({m, e});
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd <= 1'b0;
  endtask : bus
  // monitor: read data at each finished data phase, shutter length at the closing curtain edge
  always @(posedge hclk) begin : mon
    logic [63:0] n;
    cyc <= cyc + 1;
    sh <= count_start ? 0 : sh + 1;
    sc_q <= second_curtain_magnet_ctrl;
    if (rd && hreadyout) begin
      n = rq.pop_front();
      cmp(hrdata & n[63:32], n[31:0], 0);
      cmp(32'(hresp), 32'h0, 0);
    end
    if (second_curtain_magnet_ctrl && !sc_q && !count_start) cmp(sh, tq.pop_front(), 2);
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic frame(input logic [7:0] ap, input logic [15:0] st, input logic [4:0] m);
    gap <= 4'($urandom_range(0, 9));
    bus(1'b1, ADDR_APERTURE, 32'(ap), 32'h0, 32'h0);
    bus(1'b1, ADDR_SHUTTER, 32'(st), 32'h0, 32'h0);
    bus(1'b1, ADDR_MASK, 32'(m), 32'h0, 32'h0);
    bus(1'b0, ADDR_APERTURE, 32'h0, 32'hff, 32'(ap));
    tq.push_back(int'(st) * SHUT_TICK_CYC);
    rel_n <= 1'b0;
    while (count_start) @(posedge hclk);
    bus(1'b0, ADDR_STATE, 32'h0, 32'hff << STATE_AP_LSB, 32'(ap) << STATE_AP_LSB);
    while (!power_up_clear) @(posedge hclk);
    rel_n <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp(32'(irq), 32'(m != 5'h0), 0);
    cmp(32'(status_view), 32'h1e, 0);
    bus(1'b0, ADDR_STATUS, 32'h0, 32'h1f, 32'h1e);
    bus(1'b0, ADDR_STATUS, 32'h0, 32'h1f, 32'h0);
    $display("frame done");
  endtask : frame
  task automatic lockout();
    bus(1'b1, ADDR_MASK, 32'h1, 32'h0, 32'h0);
    battery_low <= 1'b1;
    rel_n <= 1'b0;
    while (!low_voltage_flag) @(posedge hclk);
    @(posedge hclk);
    cmp({30'h0, power_latch, irq}, 32'h3, 0);
    cmp(32'(status_view), 32'h1, 0);
    bus(1'b0, ADDR_STATUS, 32'h0, 32'h1f, 32'h1);
    cmp(32'(irq), 32'h0, 0);
    rel_n <= 1'b1;
    battery_low <= 1'b0;
    $display("lockout done");
  endtask : lockout
  // main sequence: reset values, ignored release, frames with a lockout between them
  initial begin
    void'($urandom(32'h2283));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_CTRL, 32'h0, 32'h1, 32'(CTRL_ENABLE_RST));
    bus(1'b0, ADDR_SHUTTER, 32'h0, 32'hffff, 32'(SHUTTER_RST));
    bus(1'b1, 8'h18, 32'h5a, 32'h0, 32'h0);
    bus(1'b0, 8'h18, 32'h0, 32'hffffffff, 32'h0);
    rel_n <= 1'b0;
    repeat (20) @(posedge hclk);
    cmp(32'(power_latch), 32'h1, 0);
    rel_n <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h1, 32'h0, 32'h0);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      if (i == 2) lockout();
      else frame((i == 1) ? 8'h0 : 8'($urandom_range(1, 4)), 16'($urandom_range(1, 2)), (i == 1) ? 5'h0 : 5'h1f);
    end
    cmp(32'(tq.size()), 32'h0, 0);
    stop_test();
  end
endmodule : tb_exposure_release_sequencer
